//--- design/store_pkg.sv
// shared constants and types for the accumulator store / indirect move block
// assumes one core clock; every user includes it through an import of the whole package
package store_pkg;

    // data path widths and pointer count
    localparam int ACC_W       = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int BANK_W      = 6;
    localparam int PTR_W       = 16;
    localparam int OFFSET_W    = 6;
    localparam int NUM_PTRS    = 2;
    localparam int ADDR_PAD_W  = PTR_W - BANK_W - FILE_ADDR_W;

    // file addresses that have no storage and redirect through a pointer
    localparam logic [FILE_ADDR_W-1:0] INDIRECT_PORT0_ADDR = 7'h00;
    localparam logic [FILE_ADDR_W-1:0] INDIRECT_PORT1_ADDR = 7'h01;

    // reset values, cause flag levels, address pad and pointer step
    localparam logic [PTR_W-1:0] PTR_RESET         = 16'h0000;
    localparam logic [ACC_W-1:0] WDATA_RESET       = 8'h00;
    localparam logic [PTR_W-1:0] ADDR_RESET        = 16'h0000;
    localparam logic             CAUSE_FLAG_IDLE   = 1'b1;
    localparam logic             CAUSE_FLAG_ACTIVE = 1'b0;
    localparam logic [ADDR_PAD_W-1:0] ADDR_PAD     = 3'h0;
    localparam logic [PTR_W-1:0] PTR_STEP          = 16'h0001;

    // instruction kinds presented by the decoder
    typedef enum logic [1:0]
    {
        OP_NONE      = 2'b00,
        OP_STORE_ACC = 2'b01,
        OP_INDIRECT  = 2'b10,
        OP_SW_RESET  = 2'b11
    } op_e;

    // pointer update mode field of the indirect store
    typedef enum logic [1:0]
    {
        MODE_PRE_INC  = 2'b00,
        MODE_PRE_DEC  = 2'b01,
        MODE_POST_INC = 2'b10,
        MODE_POST_DEC = 2'b11
    } mode_e;

endpackage

//--- design/ptr_if.sv
// bundle between the store sequencer and the pointer unit
// assumes both ends run on the same core clock and reset
`timescale 1ns/100ps
interface ptr_if;
    import store_pkg::*;

    logic                   ce;
    logic                   clear;
    logic                   go;
    logic                   sel;
    mode_e                  mode;
    logic                   rel;
    logic [OFFSET_W-1:0]    offset;
    logic                   load;
    logic                   load_sel;
    logic [PTR_W-1:0]       load_value;
    logic [PTR_W-1:0]       eff_addr;
    logic [PTR_W-1:0]       ptr_value [NUM_PTRS];

    modport unit (input ce, clear, go, sel, mode, rel, offset, load, load_sel, load_value,
                  output eff_addr, ptr_value);
    modport core (output ce, clear, go, sel, mode, rel, offset, load, load_sel, load_value,
                  input eff_addr, ptr_value);
endinterface

//--- design/pointer_unit.sv
// holds the two file-select pointers and works out the indirect store address
// assumes go and load are never raised in the same cycle for the same pointer
`timescale 1ns/100ps
module pointer_unit
    import store_pkg::*;
(
    // clock and synchronised reset
    input  wire logic clk,
    input  wire logic rst_n,
    // link to the sequencer
    ptr_if.unit       pb
);

    typedef struct packed
    {
        logic [NUM_PTRS-1:0][PTR_W-1:0] ptr;
    } ptr_state_s;

    ptr_state_s state_reg;
    ptr_state_s state_next;
    logic [PTR_W-1:0] base;
    logic [PTR_W-1:0] inc_val;
    logic [PTR_W-1:0] dec_val;
    logic [PTR_W-1:0] rel_val;

    // 16-bit adders wrap on their own; carry out is dropped and feeds no flag
    always_comb
    begin
        base    = state_reg.ptr[pb.sel];
        inc_val = base + PTR_STEP;
        dec_val = base - PTR_STEP;
        rel_val = base + {{(PTR_W-OFFSET_W){pb.offset[OFFSET_W-1]}}, pb.offset};
    end

    // effective address: pre modes use the updated value, post modes the original
    always_comb
    begin
        if (pb.rel)
            pb.eff_addr = rel_val;
        else
        begin
            case (pb.mode)
                MODE_PRE_INC:  pb.eff_addr = inc_val;
                MODE_PRE_DEC:  pb.eff_addr = dec_val;
                MODE_POST_INC: pb.eff_addr = base;
                MODE_POST_DEC: pb.eff_addr = base;
                default:       pb.eff_addr = base;
            endcase
        end
    end

    // next pointer values; clear resets both, a load moves load_sel, a step moves only the selected pointer, relative form leaves it alone
    always_comb
    begin
        state_next = state_reg;
        if (pb.clear)
        begin
            for (int i = 0; i < NUM_PTRS; i++)
                state_next.ptr[i] = PTR_RESET;
        end
        else if (pb.load)
            state_next.ptr[pb.load_sel] = pb.load_value;
        else if (pb.go && !pb.rel)
        begin
            case (pb.mode)
                MODE_PRE_INC, MODE_POST_INC: state_next.ptr[pb.sel] = inc_val;
                MODE_PRE_DEC, MODE_POST_DEC: state_next.ptr[pb.sel] = dec_val;
                default:                     state_next.ptr[pb.sel] = base;
            endcase
        end
    end

    // pointer storage, frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_PTRS; i++)
                state_reg.ptr[i] <= PTR_RESET;
        end
        else if (pb.ce)
            state_reg <= state_next;
    end

    // pointer values for redirection of the indirect access ports
    genvar g;
    generate
        for (g = 0; g < NUM_PTRS; g++)
        begin : g_out
            assign pb.ptr_value[g] = state_reg.ptr[g];
        end
    endgenerate

endmodule

//--- design/accumulator_store_and_indirect_move.sv
// execution of the accumulator store, indirect store and software reset instructions
// assumes the decoder presents one instruction per enabled cycle on the core clock,
// and that the data memory takes a write whenever mem_we is high
// the block owns no status flags; the flag logic of the core never hears from it
// a software reset asks for the device reset, clears both pointers and drives the cause flag low; the reset controller does the rest
// mem_addr and mem_wdata hold their last values between writes
`timescale 1ns/100ps

// How it works
// - direct store copies accumulator, one cycle, no flags
// - mode field picks pre/post increment or decrement
// - relative form writes pointer plus signed offset
// - indirect port redirects to pointer-held address
// - sixteen-bit pointer wraps at both ends
// - pointer stepping never touches status flags
// - software reset requests reset, drives cause flag low
module accumulator_store_and_indirect_move
    import store_pkg::*;
(
    // clock, reset and enable
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   clk_en,
    // decoded instruction
    input  wire logic                   op_valid,
    input  wire op_e                    op_kind,
    input  wire logic [FILE_ADDR_W-1:0] op_file_addr,
    input  wire logic [BANK_W-1:0]      op_bank,
    input  wire logic                   op_ptr_sel,
    input  wire mode_e                  pointer_update_mode,
    input  wire logic                   op_relative,
    input  wire logic [OFFSET_W-1:0]    op_offset,
    // working accumulator
    input  wire logic [ACC_W-1:0]       acc_value,
    // pointer load from the core
    input  wire logic                   ptr_load,
    input  wire logic                   ptr_load_sel,
    input  wire logic [PTR_W-1:0]       ptr_load_value,
    // file read address translation
    input  wire logic                   rd_valid,
    input  wire logic [FILE_ADDR_W-1:0] rd_file_addr,
    input  wire logic [BANK_W-1:0]      rd_bank,
    output logic                        rd_ack,
    output logic [PTR_W-1:0]            rd_mem_addr,
    // data memory write
    output logic                        mem_we,
    output logic [PTR_W-1:0]            mem_addr,
    output logic [ACC_W-1:0]            mem_wdata,
    // power control register cause bit and reset request
    input  wire logic                   cause_flag_set,
    output logic                        software_reset_cause_flag,
    output logic                        sw_reset_req,
    // current pointers
    output logic [PTR_W-1:0]            indirect_pointer0,
    output logic [PTR_W-1:0]            indirect_pointer1
);

    // every registered output except the two pointers lives in this one record, so clk_en freezes all of it at once
    typedef struct packed
    {
        logic             mem_we;
        logic [PTR_W-1:0] mem_addr;
        logic [ACC_W-1:0] mem_wdata;
        logic             rd_ack;
        logic [PTR_W-1:0] rd_mem_addr;
        logic             cause_n;
        logic             sw_reset_req;
    } core_state_s;

    core_state_s state_reg;
    core_state_s state_next;

    // synchronised reset, enabled instruction strobe and the pointer bundle
    logic [1:0]  rst_sync_reg;
    logic        rst_n;
    logic        exec;
    ptr_if       pb ();

    // true for a file address with no storage behind it
    // the two port addresses hold in every bank, so the bank bits play no part here
    function automatic logic is_indirect_port(input logic [FILE_ADDR_W-1:0] a);
        return (a == INDIRECT_PORT0_ADDR) || (a == INDIRECT_PORT1_ADDR);
    endfunction

    // resolve a banked file address, redirecting the indirect ports through a pointer
    // the top pad bits stay zero: banked space reaches only part of the pointer range
    function automatic logic [PTR_W-1:0] resolve_addr(
        input logic [FILE_ADDR_W-1:0] a,
        input logic [BANK_W-1:0]      bank,
        input logic [PTR_W-1:0]       p0,
        input logic [PTR_W-1:0]       p1);
        logic [PTR_W-1:0] r;
        r = {ADDR_PAD, bank, a};
        if (is_indirect_port(a))
            r = (a == INDIRECT_PORT1_ADDR) ? p1 : p0;
        return r;
    endfunction

    // reset release through two flops so every block leaves reset on the same edge
    // the pointer unit takes the same copy, so pointers and outputs leave reset together
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // an instruction counts only on an enabled edge; with clk_en low a held op_valid waits
    assign exec = op_valid && clk_en;

    // pointer unit hookup; a software reset clears both pointers with the rest of the core
    assign pb.ce         = clk_en;
    assign pb.clear      = exec && (op_kind == OP_SW_RESET);
    assign pb.go         = exec && (op_kind == OP_INDIRECT);

    // operand fields of the indirect store pass straight through
    assign pb.sel        = op_ptr_sel;
    assign pb.mode       = pointer_update_mode;
    assign pb.rel        = op_relative;
    assign pb.offset     = op_offset;

    // a core load loses to any indirect store of the same cycle, whichever pointer either one selects
    assign pb.load       = ptr_load && !pb.go;
    assign pb.load_sel   = ptr_load_sel;
    assign pb.load_value = ptr_load_value;

    pointer_unit u_pointer_unit
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pb    (pb)
    );

    // instruction execution; no status flag output exists, so none can change
    always_comb
    begin
        // pulses drop by default; address and data hold until the next write
        state_next              = state_reg;
        state_next.mem_we       = 1'b0;
        state_next.rd_ack       = 1'b0;
        state_next.sw_reset_req = 1'b0;
        if (exec)
        begin
            case (op_kind)
                // direct store: banked address, redirected at the two port addresses
                OP_STORE_ACC:
                begin
                    state_next.mem_we    = 1'b1;
                    state_next.mem_addr  = resolve_addr(op_file_addr, op_bank,
                                                        pb.ptr_value[0], pb.ptr_value[1]);
                    state_next.mem_wdata = acc_value;
                end
                // indirect store: the pointer unit works out the address and steps itself, except in the relative form
                OP_INDIRECT:
                begin
                    state_next.mem_we    = 1'b1;
                    state_next.mem_addr  = pb.eff_addr;
                    state_next.mem_wdata = acc_value;
                end
                // software reset: here only the request, as pb.clear and the cause flag are handled apart; the reset controller resets the device
                OP_SW_RESET:
                    state_next.sw_reset_req = 1'b1;
                // an empty slot does nothing
                default:
                    state_next.mem_we = 1'b0;
            endcase
        end

        // read translation runs beside any instruction
        if (rd_valid && clk_en)
        begin
            state_next.rd_ack      = 1'b1;
            state_next.rd_mem_addr = resolve_addr(rd_file_addr, rd_bank,
                                                  pb.ptr_value[0], pb.ptr_value[1]);
        end

        // cause flag: the reset event wins over a software write in the same cycle
        // a write back from software lands on the edge that sees cause_flag_set
        if (clk_en && cause_flag_set)
            state_next.cause_n = CAUSE_FLAG_IDLE;
        if (exec && op_kind == OP_SW_RESET)
            state_next.cause_n = CAUSE_FLAG_ACTIVE;
    end

    // one register for the whole record; clk_en low holds it, so pulses stretch
    // the cause flag must survive the software reset it reports, so only resetn and cause_flag_set return it to idle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.mem_we       <= 1'b0;
            state_reg.mem_addr     <= ADDR_RESET;
            state_reg.mem_wdata    <= WDATA_RESET;
            state_reg.rd_ack       <= 1'b0;
            state_reg.rd_mem_addr  <= ADDR_RESET;
            state_reg.cause_n      <= CAUSE_FLAG_IDLE;
            state_reg.sw_reset_req <= 1'b0;
        end
        else if (clk_en)
            state_reg <= state_next;
    end

    // outputs straight from flops
    assign mem_we                    = state_reg.mem_we;
    assign mem_addr                  = state_reg.mem_addr;
    assign mem_wdata                 = state_reg.mem_wdata;

    // read translation result
    assign rd_ack                    = state_reg.rd_ack;
    assign rd_mem_addr               = state_reg.rd_mem_addr;

    // reset cause and request
    assign software_reset_cause_flag = state_reg.cause_n;
    assign sw_reset_req              = state_reg.sw_reset_req;

    // pointers as held in the pointer unit
    assign indirect_pointer0         = pb.ptr_value[0];
    assign indirect_pointer1         = pb.ptr_value[1];

endmodule

//--- test/accumulator_store_and_indirect_move_asserts.sv
// concurrent checks on the store block, seeing top-level ports only
// assumes one clock domain; bound from the testbench top file
`timescale 1ns/100ps
module accumulator_store_and_indirect_move_asserts
    import store_pkg::*;
(
    // clock, reset, enable
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire logic                   clk_en,
    // instruction
    input wire logic                   op_valid,
    input wire op_e                    op_kind,
    input wire logic [FILE_ADDR_W-1:0] op_file_addr,
    input wire logic [BANK_W-1:0]      op_bank,
    input wire logic                   op_ptr_sel,
    input wire mode_e                  pointer_update_mode,
    input wire logic                   op_relative,
    input wire logic [OFFSET_W-1:0]    op_offset,
    input wire logic [ACC_W-1:0]       acc_value,
    // read translation
    input wire logic                   rd_valid,
    input wire logic [FILE_ADDR_W-1:0] rd_file_addr,
    input wire logic [BANK_W-1:0]      rd_bank,
    input wire logic                   rd_ack,
    input wire logic [PTR_W-1:0]       rd_mem_addr,
    // memory write, reset cause, pointers
    input wire logic                   mem_we,
    input wire logic [PTR_W-1:0]       mem_addr,
    input wire logic [ACC_W-1:0]       mem_wdata,
    input wire logic                   cause_flag_set,
    input wire logic                   software_reset_cause_flag,
    input wire logic                   sw_reset_req,
    input wire logic [PTR_W-1:0]       indirect_pointer0,
    input wire logic [PTR_W-1:0]       indirect_pointer1
);
    logic [PTR_W-1:0] cur_ptr, nxt_ptr, exp_addr, dir_addr, rd_exp;
    logic             ind_op, st_op, wr_op;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // file address 00h/01h has no storage, so it maps through a pointer
    function automatic logic [PTR_W-1:0] xlate(logic [FILE_ADDR_W-1:0] a, logic [BANK_W-1:0] b);
        if (a == INDIRECT_PORT0_ADDR)
            return indirect_pointer0;
        if (a == INDIRECT_PORT1_ADDR)
            return indirect_pointer1;
        return {ADDR_PAD, b, a};
    endfunction

    // expected values; post modes write the old pointer, pre modes the stepped one
    always_comb
    begin
        ind_op   = clk_en && op_valid && op_kind == OP_INDIRECT;
        st_op    = clk_en && op_valid && op_kind == OP_STORE_ACC;
        wr_op    = ind_op || st_op;
        cur_ptr  = op_ptr_sel ? indirect_pointer1 : indirect_pointer0;
        nxt_ptr  = pointer_update_mode[0] ? cur_ptr - PTR_STEP : cur_ptr + PTR_STEP;
        exp_addr = pointer_update_mode[1] ? cur_ptr : nxt_ptr;
        if (op_relative)
            exp_addr = cur_ptr + {{(PTR_W-OFFSET_W){op_offset[OFFSET_W-1]}}, op_offset};
        dir_addr = xlate(op_file_addr, op_bank);
        rd_exp   = xlate(rd_file_addr, rd_bank);
    end

    // write port timing and content
    property p_direct;
        st_op |=> mem_we && mem_wdata == $past(acc_value) && mem_addr == $past(dir_addr);
    endproperty
    a_direct: assert property (p_direct) else $error("direct store wrong");
    property p_ind_addr;
        ind_op |=> mem_we && mem_wdata == $past(acc_value) && mem_addr == $past(exp_addr);
    endproperty
    a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");
    property p_we_cause;
        mem_we && $past(clk_en) |-> $past(wr_op);
    endproperty
    a_we_cause: assert property (p_we_cause) else $error("write without store");

    // pointer updates
    property p_ind_step;
        ind_op && !op_relative |=>
            ($past(op_ptr_sel) ? indirect_pointer1 : indirect_pointer0) == $past(nxt_ptr);
    endproperty
    a_ind_step: assert property (p_ind_step) else $error("pointer step wrong");
    property p_rel_keep;
        ind_op && op_relative |=> $stable(indirect_pointer0) && $stable(indirect_pointer1);
    endproperty
    a_rel_keep: assert property (p_rel_keep) else $error("relative moved pointer");

    // read translation and software reset
    property p_read;
        clk_en && rd_valid |=> rd_ack && rd_mem_addr == $past(rd_exp);
    endproperty
    a_read: assert property (p_read) else $error("read translation wrong");
    property p_reset;
        clk_en && op_valid && op_kind == OP_SW_RESET |=> sw_reset_req
            && software_reset_cause_flag == CAUSE_FLAG_ACTIVE && indirect_pointer0 == PTR_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("software reset wrong");
    property p_flag_hold;
        software_reset_cause_flag == CAUSE_FLAG_ACTIVE && !cause_flag_set
            |=> software_reset_cause_flag == CAUSE_FLAG_ACTIVE;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("cause flag lost");
endmodule

//--- test/accumulator_store_and_indirect_move_tb.sv
// self-checking bench for the accumulator store block
// assumes the package is compiled first; inputs change on the falling edge
`timescale 1ns/100ps
module accumulator_store_and_indirect_move_tb
    import store_pkg::*;
;
    logic clk, resetn, clk_en, op_valid, op_ptr_sel, op_relative, ptr_load, ptr_load_sel;
    logic rd_valid, rd_ack, mem_we, cause_flag_set, software_reset_cause_flag, sw_reset_req;
    op_e                    op_kind;
    mode_e                  pointer_update_mode;
    logic [FILE_ADDR_W-1:0] op_file_addr, rd_file_addr;
    logic [BANK_W-1:0]      op_bank, rd_bank;
    logic [OFFSET_W-1:0]    op_offset;
    logic [ACC_W-1:0]       acc_value, mem_wdata;
    logic [PTR_W-1:0]       ptr_load_value, rd_mem_addr, mem_addr;
    logic [PTR_W-1:0]       indirect_pointer0, indirect_pointer1;
    int                     failures, num_checks;

    accumulator_store_and_indirect_move u_accumulator_store_and_indirect_move (.*);

    // 100 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(string what, logic [PTR_W-1:0] seen, logic [PTR_W-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // one instruction; returns on the falling edge after the edge that took it
    task automatic issue(op_e k, logic [6:0] f, logic [5:0] b, logic s, mode_e m, logic r,
                         logic [5:0] o, logic [7:0] a);
        {op_valid, op_kind, op_file_addr, op_bank} = {1'b1, k, f, b};
        {op_ptr_sel, pointer_update_mode, op_relative, op_offset, acc_value} = {s, m, r, o, a};
        @(negedge clk);
    endtask

    task automatic idle();
        op_valid = 1'b0;
        rd_valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic load(logic s, logic [PTR_W-1:0] v);
        {ptr_load, ptr_load_sel, ptr_load_value} = {1'b1, s, v};
        @(negedge clk);
        ptr_load = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(logic [6:0] f, logic [5:0] b, logic [PTR_W-1:0] e);
        {rd_valid, rd_file_addr, rd_bank} = {1'b1, f, b};
        @(negedge clk);
        check("rd_ack", rd_ack, 1'b1);
        check("rd_mem_addr", rd_mem_addr, e);
    endtask

    task automatic t_direct();
        load(1'b1, 16'h1234);
        issue(OP_STORE_ACC, 7'h25, 6'h02, 1'b0, MODE_PRE_INC, 1'b0, 6'h00, 8'h4F);
        check("mem_addr", mem_addr, 16'h0125);
        issue(OP_STORE_ACC, 7'h7F, 6'h3F, 1'b0, MODE_PRE_INC, 1'b0, 6'h00, 8'hA5);
        check("mem_addr", mem_addr, 16'h1FFF);
        check("mem_wdata", mem_wdata, 8'hA5);
        issue(OP_STORE_ACC, INDIRECT_PORT1_ADDR, 6'h05, 1'b0, MODE_PRE_INC, 1'b0, 6'h00, 8'h3C);
        check("mem_addr", mem_addr, 16'h1234);
        check("pointer1", indirect_pointer1, 16'h1234);
        idle();
        check("mem_we", mem_we, 1'b0);
    endtask

    // both pointers from FFFFh, all four modes back to back, crossing both ends
    task automatic t_modes();
        logic [PTR_W-1:0] p, e;
        load(1'b0, 16'hFFFF);
        load(1'b1, 16'hFFFF);
        for (int s = 0; s < 2; s++)
        begin
            p = 16'hFFFF;
            for (int m = 0; m < 4; m++)
            begin
                e = m[0] ? p - 16'h0001 : p + 16'h0001;
                issue(OP_INDIRECT, 7'h00, 6'h00, s[0], mode_e'(m[1:0]), 1'b0, 6'h00, 8'h77);
                check("mem_addr", mem_addr, m[1] ? p : e);
                p = e;
                check("pointer", s[0] ? indirect_pointer1 : indirect_pointer0, p);
                check("other", s[0] ? indirect_pointer0 : indirect_pointer1, 16'hFFFF);
            end
        end
        idle();
    endtask

    task automatic t_rel();
        load(1'b0, 16'h0010);
        issue(OP_INDIRECT, 7'h00, 6'h00, 1'b0, MODE_POST_DEC, 1'b1, 6'h20, 8'h11);
        check("mem_addr", mem_addr, 16'hFFF0);
        issue(OP_INDIRECT, 7'h00, 6'h00, 1'b0, MODE_PRE_INC, 1'b1, 6'h1F, 8'h22);
        check("mem_addr", mem_addr, 16'h002F);
        issue(OP_INDIRECT, 7'h00, 6'h00, 1'b0, MODE_POST_INC, 1'b1, 6'h3F, 8'h33);
        check("mem_addr", mem_addr, 16'h000F);
        check("pointer0", indirect_pointer0, 16'h0010);
        idle();
    endtask

    task automatic t_read();
        rd(INDIRECT_PORT0_ADDR, 6'h01, 16'h0010);
        rd(INDIRECT_PORT1_ADDR, 6'h01, 16'hFFFF);
        rd(7'h25, 6'h02, 16'h0125);
        idle();
        check("rd_ack", rd_ack, 1'b0);
    endtask

    // the cause flag stays active until software writes it back
    task automatic t_reset();
        check("cause", software_reset_cause_flag, CAUSE_FLAG_IDLE);
        issue(OP_SW_RESET, 7'h00, 6'h00, 1'b0, MODE_PRE_INC, 1'b0, 6'h00, 8'h00);
        check("sw_reset_req", sw_reset_req, 1'b1);
        check("pointer1", indirect_pointer1, PTR_RESET);
        idle();
        check("sw_reset_req", sw_reset_req, 1'b0);
        check("cause", software_reset_cause_flag, CAUSE_FLAG_ACTIVE);
        cause_flag_set = 1'b1;
        @(negedge clk);
        check("cause", software_reset_cause_flag, CAUSE_FLAG_IDLE);
        // a write back in the reset's own cycle loses to the reset event
        issue(OP_SW_RESET, 7'h00, 6'h00, 1'b0, MODE_PRE_INC, 1'b0, 6'h00, 8'h00);
        cause_flag_set = 1'b0;
        check("cause", software_reset_cause_flag, CAUSE_FLAG_ACTIVE);
        idle();
    endtask

    // clock enable low holds a pending store and the pointers until it returns
    task automatic t_enable();
        clk_en = 1'b0;
        issue(OP_INDIRECT, 7'h00, 6'h00, 1'b1, MODE_POST_INC, 1'b0, 6'h00, 8'h5A);
        check("mem_we", mem_we, 1'b0);
        check("pointer1", indirect_pointer1, PTR_RESET);
        clk_en = 1'b1;
        @(negedge clk);
        check("mem_we", mem_we, 1'b1);
        check("mem_addr", mem_addr, PTR_RESET);
        check("mem_wdata", mem_wdata, 8'h5A);
        check("pointer1", indirect_pointer1, 16'h0001);
        idle();
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {resetn, op_valid, op_ptr_sel, op_relative, ptr_load, ptr_load_sel, rd_valid} = '0;
        {cause_flag_set, op_file_addr, op_bank, op_offset, acc_value, ptr_load_value} = '0;
        {rd_file_addr, rd_bank} = '0;
        op_kind = OP_NONE;
        pointer_update_mode = MODE_PRE_INC;
        clk_en = 1'b1;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(negedge clk);
        check("pointer0", indirect_pointer0, PTR_RESET);
        t_direct();
        t_modes();
        t_rel();
        t_read();
        t_reset();
        t_enable();
        wrap_up();
    end

    // watchdog, far beyond the 44 or so cycles the run needs
    initial
    begin
        #20000;
        failures++;
        wrap_up();
    end
endmodule

bind accumulator_store_and_indirect_move accumulator_store_and_indirect_move_asserts
    u_accumulator_store_and_indirect_move_asserts (.*);
